// >>> common/trip_switch_pkg.sv
// constants and types shared by the temperature trip switch
package trip_switch_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned PERIOD_MS = 600;
  localparam int unsigned CONV_MS = 30;
  localparam int unsigned PERIOD_CYCLES = PERIOD_MS * CLK_PER_MS;
  localparam int unsigned CONV_CYCLES = CONV_MS * CLK_PER_MS;
  localparam int unsigned CNT_W = 24;

  // ****************************************
  // temperature word
  // ****************************************
  localparam int unsigned TEMP_W = 12;
  localparam int unsigned LSB_PER_DEG = 8;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 12'h000;

  // ****************************************
  // three-level select encoding
  // ****************************************
  localparam logic [1:0] SEL_LOW = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_FLOAT = 2'h2;

  // ****************************************
  // trip table, values in 1/8 degree steps
  // ****************************************
  localparam logic [4:0] IDX_OVER_LARGE = 5'h08;
  localparam logic [4:0] IDX_UNDER_SMALL = 5'h0F;
  localparam logic [4:0] IDX_UNDER_LARGE = 5'h15;
  localparam logic [TEMP_W-1:0] OVER_SMALL_BASE = 12'h168;
  localparam logic [TEMP_W-1:0] OVER_LARGE_BASE = 12'h1B8;
  localparam logic [TEMP_W-1:0] UNDER_BASE = 12'h028;
  localparam logic [TEMP_W-1:0] TRIP_STEP = 12'h050;
  localparam logic [TEMP_W-1:0] HYST_SMALL = 12'h010;
  localparam logic [TEMP_W-1:0] HYST_LARGE = 12'h050;

  // ****************************************
  // sequencer states, gray from convert through eval to sleep
  // ****************************************
  typedef enum logic [1:0] {
    ST_CONVERT = 2'h0,
    ST_EVAL = 2'h1,
    ST_SLEEP = 2'h3
  } seq_state_t;

endpackage : trip_switch_pkg

// >>> rtl/trip_select_decode.sv
// decode of the three three-level select pins into trip point and hysteresis
`timescale 1ns/10ps
module trip_select_decode (
  input wire logic [1:0] trip_select_2_i,
  input wire logic [1:0] trip_select_1_i,
  input wire logic [1:0] trip_select_0_i,
  output logic [11:0] trip_level_o,
  output logic [11:0] hysteresis_o,
  output logic under_mode_o
);

  // ****************************************
  // helpers
  // ****************************************
  // an illegal code is read as floating, the pin's default state
  function automatic logic [4:0] digit(input logic [1:0] code);
    logic [4:0] v;
    v = 5'h02;
    if (code == trip_switch_pkg::SEL_LOW) begin
      v = 5'h00;
    end else if (code == trip_switch_pkg::SEL_HIGH) begin
      v = 5'h01;
    end
    return v;
  endfunction : digit

  function automatic logic [11:0] steps(input logic [4:0] n);
    logic [11:0] acc;
    acc = 12'h000;
    for (int i = 0; i < 8; i++) begin
      if (5'(i) < n) begin
        acc = acc + trip_switch_pkg::TRIP_STEP;
      end
    end
    return acc;
  endfunction : steps

  // ****************************************
  // index into the table
  // ****************************************
  wire [4:0] d2 = digit(trip_select_2_i);
  wire [4:0] d1 = digit(trip_select_1_i);
  wire [4:0] d0 = digit(trip_select_0_i);
  wire [4:0] idx = 5'(d2 * 5'h09 + d1 * 5'h03 + d0);

  wire in_over_small = idx < trip_switch_pkg::IDX_OVER_LARGE;
  wire in_over_large = !in_over_small && (idx < trip_switch_pkg::IDX_UNDER_SMALL);
  wire in_under_small = !in_over_small && !in_over_large && (idx < trip_switch_pkg::IDX_UNDER_LARGE);

  wire [11:0] over_small_trip = trip_switch_pkg::OVER_SMALL_BASE + steps(idx);
  wire [11:0] over_large_trip = trip_switch_pkg::OVER_LARGE_BASE
                                + steps(5'(idx - trip_switch_pkg::IDX_OVER_LARGE));
  wire [11:0] under_small_trip = trip_switch_pkg::UNDER_BASE
                                 - steps(5'(idx - trip_switch_pkg::IDX_UNDER_SMALL));
  wire [11:0] under_large_trip = trip_switch_pkg::UNDER_BASE
                                 - steps(5'(idx - trip_switch_pkg::IDX_UNDER_LARGE));

  assign trip_level_o = in_over_small ? over_small_trip :
                        in_over_large ? over_large_trip :
                        in_under_small ? under_small_trip : under_large_trip;
  assign hysteresis_o = (in_over_small || in_under_small) ? trip_switch_pkg::HYST_SMALL
                                                          : trip_switch_pkg::HYST_LARGE;
  assign under_mode_o = !in_over_small && !in_over_large;

endmodule : trip_select_decode

// >>> rtl/temperature_trip_switch.sv
// conversion sequencer, comparator with hysteresis and trip output driver
// Operation
// - all timing comes from the block's own clock, with no clock from outside needed.
// - a free-running timer starts a new conversion once every 600 ms.
// - the analog section is powered for 30 ms at the start of each period and off for the other 570 ms.
// - the trip output only becomes valid after the first conversion, about 30 ms after power-up.
// - each result is a 12-bit two's complement word, compared as a signed value by the comparator.
// - in overtemperature mode the output trips when the result exceeds the trip value.
// - in undertemperature mode the output trips when the result is below the trip value.
// - once tripped, the output holds until the result moves back past the trip by the hysteresis.
// - codes 000 to 0F1 select overtemperature trips of +45 to +115 C with 2 C hysteresis.
// - codes 0FF to 11F select overtemperature trips of +55 to +115 C with 10 C hysteresis.
// - codes 1F0 to F0F select undertemperature trips of +5 to -45 C with 2 C hysteresis.
// - codes F10 to FFF select undertemperature trips of +5 to -45 C with 10 C hysteresis.
// - the trip pin is active-low open-drain in one variant and active-high push-pull in the other.
`timescale 1ns/10ps
module temperature_trip_switch #(
  parameter bit PUSH_PULL = 1'b1,
  parameter int unsigned PERIOD_CYCLES = trip_switch_pkg::PERIOD_CYCLES,
  parameter int unsigned CONV_CYCLES = trip_switch_pkg::CONV_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] temp_word_i,
  input wire logic [1:0] trip_select_2_i,
  input wire logic [1:0] trip_select_1_i,
  input wire logic [1:0] trip_select_0_i,
  output logic analog_power_o,
  output logic conv_done_o,
  output logic [11:0] conv_result_o,
  output logic result_valid_o,
  output logic trip_output_o,
  output logic trip_output_oe_o,
  output logic over_temp_output_o,
  output logic under_temp_output_o
);

  localparam int unsigned CNT_W = trip_switch_pkg::CNT_W;
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the counter is sized for the documented period; longer periods need a wider counter
  if (PERIOD_CYCLES > (1 << CNT_W)) begin : g_bad_period
    $error("period does not fit the timer");
  end
  if (CONV_CYCLES < 1 || CONV_CYCLES + 2 > PERIOD_CYCLES) begin : g_bad_conv
    $error("conversion window must be shorter than the period");
  end

  // ****************************************
  // period timer
  // ****************************************
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire period_end = (cnt_q == PERIOD_LAST);
  wire conv_end = (cnt_q == CONV_LAST);

  assign cnt_d = period_end ? '0 : CNT_W'(cnt_q + 1'b1);

  // runs on mclk_i only; nothing external paces it
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  trip_switch_pkg::seq_state_t state_q;
  trip_switch_pkg::seq_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      trip_switch_pkg::ST_CONVERT: begin
        if (conv_end) begin
          state_d = trip_switch_pkg::ST_EVAL;
        end
      end
      trip_switch_pkg::ST_EVAL: begin
        state_d = trip_switch_pkg::ST_SLEEP;
      end
      trip_switch_pkg::ST_SLEEP: begin
        if (period_end) begin
          state_d = trip_switch_pkg::ST_CONVERT;
        end
      end
      default: begin
        state_d = trip_switch_pkg::ST_CONVERT;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= trip_switch_pkg::ST_CONVERT;
    end else begin
      state_q <= state_d;
    end
  end

  wire eval_now = (state_q == trip_switch_pkg::ST_EVAL);

  // ****************************************
  // select sampling and decode
  // ****************************************
  // pins are captured at the end of each conversion window so a strap change takes
  // effect on the next result and never mid-compare
  logic [1:0] sel2_q;
  logic [1:0] sel1_q;
  logic [1:0] sel0_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sel2_q <= trip_switch_pkg::SEL_FLOAT;
      sel1_q <= trip_switch_pkg::SEL_FLOAT;
      sel0_q <= trip_switch_pkg::SEL_FLOAT;
    end else if (state_q == trip_switch_pkg::ST_CONVERT && conv_end) begin
      sel2_q <= trip_select_2_i;
      sel1_q <= trip_select_1_i;
      sel0_q <= trip_select_0_i;
    end
  end

  logic [11:0] trip_level;
  logic [11:0] hysteresis;
  logic under_mode;

  trip_select_decode u_decode (
    .trip_select_2_i(sel2_q),
    .trip_select_1_i(sel1_q),
    .trip_select_0_i(sel0_q),
    .trip_level_o(trip_level),
    .hysteresis_o(hysteresis),
    .under_mode_o(under_mode)
  );

  // ****************************************
  // result capture
  // ****************************************
  logic [11:0] result_q;
  logic valid_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_q <= trip_switch_pkg::TEMP_RESET;
      valid_q <= 1'b0;
    end else if (state_q == trip_switch_pkg::ST_CONVERT && conv_end) begin
      result_q <= temp_word_i;
      valid_q <= 1'b1;
    end
  end

  // ****************************************
  // comparator with hysteresis
  // ****************************************
  wire signed [11:0] temp_s = $signed(result_q);
  wire signed [11:0] trip_s = $signed(trip_level);
  wire signed [11:0] over_release = $signed(12'(trip_level - hysteresis));
  wire signed [11:0] under_release = $signed(12'(trip_level + hysteresis));

  wire over_set = temp_s > trip_s;
  wire over_hold = temp_s > over_release;
  wire under_set = temp_s < trip_s;
  wire under_hold = temp_s < under_release;

  logic tripped_q;
  logic tripped_d;

  // a mode change by the straps restarts from the plain threshold test
  logic mode_q;
  wire mode_same = (mode_q == under_mode);
  wire keep_over = tripped_q && mode_same ? over_hold : over_set;
  wire keep_under = tripped_q && mode_same ? under_hold : under_set;

  assign tripped_d = under_mode ? keep_under : keep_over;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tripped_q <= 1'b0;
      mode_q <= 1'b0;
    end else if (eval_now) begin
      tripped_q <= tripped_d;
      mode_q <= under_mode;
    end
  end

  // ****************************************
  // output registers
  // ****************************************
  // next values come from the comparator so every pin updates in the same cycle
  logic power_q;
  logic done_q;
  logic pin_q;
  logic oe_q;
  logic over_q;
  logic under_q;
  wire power_d = (state_d == trip_switch_pkg::ST_CONVERT);
  wire active_d = eval_now ? tripped_d : tripped_q;
  wire under_d = eval_now ? under_mode : mode_q;
  // open-drain drives low only while tripped; push-pull drives the level always
  wire pin_d = PUSH_PULL ? active_d : 1'b0;
  wire oe_d = PUSH_PULL ? 1'b1 : active_d;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      power_q <= 1'b1;
      done_q <= 1'b0;
      pin_q <= 1'b0;
      oe_q <= PUSH_PULL;
      over_q <= 1'b0;
      under_q <= 1'b0;
    end else begin
      power_q <= power_d;
      done_q <= eval_now;
      pin_q <= pin_d;
      oe_q <= oe_d;
      over_q <= active_d && !under_d;
      under_q <= active_d && under_d;
    end
  end

  assign analog_power_o = power_q;
  assign conv_done_o = done_q;
  assign conv_result_o = result_q;
  assign result_valid_o = valid_q;
  assign trip_output_o = pin_q;
  assign trip_output_oe_o = oe_q;
  assign over_temp_output_o = over_q;
  assign under_temp_output_o = under_q;

endmodule : temperature_trip_switch

// >>> testbench/trip_switch_chk.sv
// concurrent checks on the trip switch ports
`timescale 1ns/10ps
module trip_switch_chk #(
  parameter bit PUSH_PULL = 1'b1,
  parameter int unsigned PERIOD_CYCLES = 40,
  parameter int unsigned CONV_CYCLES = 4
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] temp_word_i,
  input wire logic analog_power_o,
  input wire logic conv_done_o,
  input wire logic [11:0] conv_result_o,
  input wire logic result_valid_o,
  input wire logic trip_output_o,
  input wire logic trip_output_oe_o,
  input wire logic over_temp_output_o,
  input wire logic under_temp_output_o
);
  // ****************************************
  // cycle counters
  // ****************************************
  logic [23:0] on_q;
  logic [23:0] off_q;
  logic [23:0] gap_q;
  logic seen_q;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge mclk_i) begin
    on_q <= (rst_i || !analog_power_o) ? 24'h000000 : on_q + 24'h000001;
    off_q <= (rst_i || analog_power_o) ? 24'h000000 : off_q + 24'h000001;
    gap_q <= rst_i ? 24'h000000 : (conv_done_o ? 24'h000001 : gap_q + 24'h000001);
    seen_q <= rst_i ? 1'b0 : (seen_q | conv_done_o);
  end
  AST_POWER_ON: assert property ($fell(analog_power_o) |-> on_q == 24'(CONV_CYCLES))
    else $error("analog window length wrong");
  AST_POWER_OFF: assert property ($rose(analog_power_o) |-> off_q == 24'(PERIOD_CYCLES - CONV_CYCLES))
    else $error("analog off time wrong");
  AST_PERIOD: assert property (conv_done_o && seen_q |-> gap_q == 24'(PERIOD_CYCLES))
    else $error("conversion spacing wrong");
  AST_DONE_AFTER_WINDOW: assert property ($fell(analog_power_o) |=> conv_done_o ##1 !conv_done_o)
    else $error("done pulse not after window");
  AST_FIRST_VALID: assert property ($rose(result_valid_o) |=> conv_done_o)
    else $error("valid not followed by done");
  AST_NO_TRIP_BEFORE_VALID: assert property (!result_valid_o |-> !over_temp_output_o && !under_temp_output_o)
    else $error("trip before first result");
  AST_TRIP_ON_DONE: assert property ($changed(over_temp_output_o) || $changed(under_temp_output_o)
    |-> conv_done_o)
    else $error("trip changed off a conversion");
  AST_RESULT_HOLD: assert property ($changed(conv_result_o) |=> conv_done_o)
    else $error("result changed off a conversion");
  AST_OVER_LEVEL: assert property ($rose(over_temp_output_o) |-> $signed(conv_result_o) > $signed(12'h168))
    else $error("over trip below lowest point");
  AST_UNDER_LEVEL: assert property ($rose(under_temp_output_o) |-> $signed(conv_result_o) < $signed(12'h028))
    else $error("under trip above highest point");
  AST_PIN: assert property (PUSH_PULL ? (trip_output_oe_o && trip_output_o == (over_temp_output_o | under_temp_output_o))
    : (!trip_output_o && trip_output_oe_o == (over_temp_output_o | under_temp_output_o)))
    else $error("trip pin drive wrong");
endmodule : trip_switch_chk

bind temperature_trip_switch trip_switch_chk #(.PUSH_PULL(PUSH_PULL), .PERIOD_CYCLES(PERIOD_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)) chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .temp_word_i(temp_word_i),
  .analog_power_o(analog_power_o), .conv_done_o(conv_done_o), .conv_result_o(conv_result_o),
  .result_valid_o(result_valid_o), .trip_output_o(trip_output_o), .trip_output_oe_o(trip_output_oe_o),
  .over_temp_output_o(over_temp_output_o), .under_temp_output_o(under_temp_output_o));

// >>> testbench/trip_monitor_model.sv
// reset input or fan control watching the trip pin
`timescale 1ns/10ps
module trip_monitor_model (
  input wire logic pin_out_i,
  input wire logic pin_oe_i,
  output logic level_o
);
  // pull-up holds the line high whenever nothing drives it; the bench reads the line level,
  // so polarity is judged there per variant
  assign level_o = pin_oe_i ? pin_out_i : 1'b1;
endmodule : trip_monitor_model

// >>> testbench/temperature_trip_switch_tb.sv
// self-checking bench for the temperature trip switch
`timescale 1ns/10ps
module temperature_trip_switch_tb;
  logic mclk_i, rst_i, pwr, done, valid, tout, toe, over, under, od_out, od_oe, a_pp, a_od;
  logic [11:0] temp, res, p, h;
  logic [1:0] s2, s1, s0;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [19:0] ROWS [16] = '{{6'h00, 12'h168, 2'b00}, {6'h00, 12'h169, 2'b10}, {6'h00, 12'h159, 2'b10},
    {6'h00, 12'h158, 2'b00}, {6'h0A, 12'h1B9, 2'b10}, {6'h0A, 12'h169, 2'b10}, {6'h0A, 12'h168, 2'b00},
    {6'h18, 12'h028, 2'b00}, {6'h18, 12'h027, 2'b01}, {6'h18, 12'h037, 2'b01}, {6'h18, 12'h038, 2'b00},
    {6'h24, 12'h000, 2'b01}, {6'h24, 12'h077, 2'b01}, {6'h24, 12'h078, 2'b00}, {6'h3F, 12'hE97, 2'b01},
    {6'h00, 12'hE97, 2'b00}};
  localparam int unsigned PER_CYC = 40;
  localparam int unsigned CONV_CYC = 4;
  temperature_trip_switch #(.PERIOD_CYCLES(PER_CYC), .CONV_CYCLES(CONV_CYC)) dut_u (.mclk_i(mclk_i),
    .rst_i(rst_i), .temp_word_i(temp), .trip_select_2_i(s2), .trip_select_1_i(s1), .trip_select_0_i(s0),
    .analog_power_o(pwr), .conv_done_o(done), .conv_result_o(res), .result_valid_o(valid), .trip_output_o(tout),
    .trip_output_oe_o(toe), .over_temp_output_o(over), .under_temp_output_o(under));
  temperature_trip_switch #(.PUSH_PULL(1'b0), .PERIOD_CYCLES(PER_CYC), .CONV_CYCLES(CONV_CYC)) dut_od_u (
    .mclk_i(mclk_i),
    .rst_i(rst_i), .temp_word_i(temp), .trip_select_2_i(s2), .trip_select_1_i(s1), .trip_select_0_i(s0),
    .analog_power_o(), .conv_done_o(), .conv_result_o(), .result_valid_o(), .trip_output_o(od_out),
    .trip_output_oe_o(od_oe), .over_temp_output_o(), .under_temp_output_o());
  trip_monitor_model pp_mon_u (.pin_out_i(tout), .pin_oe_i(toe), .level_o(a_pp));
  trip_monitor_model od_mon_u (.pin_out_i(od_out), .pin_oe_i(od_oe), .level_o(a_od));
  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // inputs change in sleep, so the next conversion takes them
  task automatic apply(input logic [5:0] sel, input logic [11:0] t, input logic eo, input logic eu);
    int n;
    n = 0;
    @(negedge mclk_i);
    {s2, s1, s0} = sel;
    temp = t;
    do begin
      @(negedge mclk_i);
      n++;
    end while (done !== 1'b1 && n < 60);
    check({11'h000, done}, 12'h001);
    check(res, t);
    // push-pull line goes high when tripped, open-drain line is pulled low
    check({8'h00, a_pp, a_od, over, under}, {8'h00, eo | eu, !(eo | eu), eo, eu});
  endtask : apply
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles > 6000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    temp = 12'h168;
    {s2, s1, s0} = 6'h00;
    repeat (4) @(negedge mclk_i);
    check({8'h00, pwr, valid, toe, od_oe}, 12'h00A);
    rst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    check({10'h000, valid, over}, 12'h000);
    // first conversion takes the reset-time inputs; let it finish so the rows start in sleep
    while (done !== 1'b1) @(negedge mclk_i);
    check({11'h000, valid}, 12'h001);
    check(res, 12'h168);
    check({10'h000, over, a_pp}, 12'h000);
    for (int i = 0; i < 16; i++) apply(ROWS[i][19:14], ROWS[i][13:2], ROWS[i][1], ROWS[i][0]);
    for (int a = 0; a < 3; a++)
      for (int b = 0; b < 3; b++)
        for (int c = 0; c < 3; c++) begin
          automatic int i = a * 9 + b * 3 + c;
          h = (i < 8 || (i > 14 && i < 21)) ? 12'h010 : 12'h050;
          p = i < 8 ? 12'h168 + 12'(i) * 12'h050 : i < 15 ? 12'h1B8 + 12'(i - 8) * 12'h050 :
            i < 21 ? 12'h028 - 12'(i - 15) * 12'h050 : 12'h028 - 12'(i - 21) * 12'h050;
          if (i < 15) begin
            apply({2'(a), 2'(b), 2'(c)}, p + 12'h001, 1'b1, 1'b0);
            apply({2'(a), 2'(b), 2'(c)}, p - h, 1'b0, 1'b0);
          end else begin
            apply({2'(a), 2'(b), 2'(c)}, p - 12'h001, 1'b0, 1'b1);
            apply({2'(a), 2'(b), 2'(c)}, p + h, 1'b0, 1'b0);
          end
        end
    apply(6'h00, 12'h169, 1'b1, 1'b0);
    // reset in mid-run while tripped
    rst_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    check({6'h00, pwr, valid, over, a_pp, a_od, toe}, 12'h023);
    rst_i = 1'b0;
    repeat (3) @(negedge mclk_i);
    check({10'h000, valid, a_pp}, 12'h000);
    apply(6'h00, 12'h169, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule : temperature_trip_switch_tb
